// [inc/mads_consts.vh]
// Purpose: constants of the microcoded alu/shifter datapath
// Assumes: one 50 MHz clock, apb register access
// Notes: register offsets are byte addresses of aligned words
`ifndef MADS_CONSTS_VH
`define MADS_CONSTS_VH
`define MADS_W 16
`define MADS_NREG 32
// apb offsets
`define MADS_A_INSTR 12'h000
`define MADS_A_CONST 12'h004
`define MADS_A_FLAGS 12'h008
`define MADS_A_AUX 12'h00C
`define MADS_A_IRQ 12'h010
`define MADS_A_STAT 12'h014
`define MADS_A_EXT0 12'h018
`define MADS_A_EXT1 12'h01C
`define MADS_A_RF 12'h100
// operand codes (6 bits)
`define MADS_OP_AUX 6'h20
`define MADS_OP_EXT0 6'h21
`define MADS_OP_EXT1 6'h22
`define MADS_OP_CONST 6'h23
`define MADS_OP_SW 6'h24
// alu ops
`define MADS_ALU_NOP 2'h0
`define MADS_ALU_ADD 2'h1
`define MADS_ALU_ADC 2'h2
`define MADS_ALU_AND 2'h3
// secondary ops
`define MADS_SEC_NONE 3'h0
`define MADS_SEC_COPY 3'h1
`define MADS_SEC_SHL 3'h2
`define MADS_SEC_SHLD 3'h3
`define MADS_SEC_SHR 3'h4
// fill codes
`define MADS_F_Z 3'h0
`define MADS_F_CY 3'h1
`define MADS_F_S 3'h2
`define MADS_F_0 3'h3
`define MADS_F_1 3'h4
`define MADS_F_OWN 3'h5
`define MADS_F_AUX 3'h6
`define MADS_F_SERIAL_DATA_PIN 3'h7
// flow codes
`define MADS_FLOW_CONT 2'h0
`define MADS_FLOW_ALLOW 2'h1
`define MADS_FLOW_CLR 2'h2
// instruction fields
`define MADS_I_DST 5:0
`define MADS_I_S1 11:6
`define MADS_I_S2 17:12
`define MADS_I_ALU 19:18
`define MADS_I_TWO 20
`define MADS_I_SEC 23:21
`define MADS_I_F1 26:24
`define MADS_I_F2 29:27
`define MADS_I_FLOW 31:30
// flags register bits
`define MADS_FL_Z 0
`define MADS_FL_CY 1
`define MADS_FL_S 2
`define MADS_FL_O 3
`define MADS_RST_16 16'h0000
`define MADS_RST_8 8'h00
`define MADS_RST_1 1'h0
`define MADS_RST_2 2'h0
`define MADS_RST_4 4'h0
`define MADS_RST_32 32'h0000_0000
// output control field of the instruction word
`define MADS_I_OUT 7:0
`endif

// [logic/mads_datapath.v]
// Purpose: alu/shifter datapath with flags, parallel copy and service lock
// Assumes: apb slave, one clock, instructions written by software
// Notes: illegal operand combinations are refused and counted in status
//    switch word is quasi-static: its bits are synchronised one by one
//    a copy wins over the primary result on the same external register
`timescale 1ns/1ps
`include "mads_consts.vh"

// Behaviour
// - two-operand add writes dest plus source
// - three-operand add stores two sources' sum
// - add-with-carry adds carry flag too
// - and combines operands bitwise into dest
// - add, adc, and update z cy s o
// - two-operand form needs internal operand
// - three-operand: internal source, distinct internals
// - sixteen-bit datapath with carry out
// - flow, alu, output field act together
// - immediate constant forces plain continue flow
// - servicing an interrupt sets service lock
// - allow op clears lock, flags untouched
// - serviced interrupt's pending bit auto-cleared
// - parallel copy internal reg to external
// - copy requires internal primary destination
// - left shift result, fill lsb
// - left fill: z cy s 0 1 own aux serial_data_pin
// - double shift also shifts aux register unless aux is the destination
// - right shift result, fill msb
// - right fill uses bottom bits instead
// - shifts need all-internal primary operands
// - left shift leaves flags to alu
// - single right shift updates z cy s, o from alu
module mads_datapath (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // pins
   input wire serial_data_pin,
   input wire [7:0] irq_in,
   input wire [15:0] switch_value_input,
   output reg [7:0] output_control_field,
   output reg [15:0] data_output_reg,
   output reg [15:0] port_output_reg,
   output reg irq_service_r
);

   reg [15:0] rf [0:31];
   reg [15:0] aux_r;
   reg [15:0] const_r;
   reg [3:0] flags_r;
   reg lock_r;
   reg [7:0] pend_r;
   reg [7:0] mask_r;
   reg [7:0] err_cnt_r;
   reg go_r;
   reg [31:0] instr_r;
   reg [1:0] sd_s;
   reg [7:0] irq_s1;
   reg [7:0] irq_s2;
   reg [7:0] irq_d;
   reg [15:0] sw_s1;
   reg [15:0] sw_s2;
   integer i;

   ////////////////////////////////////////////////////////////////////////
   function is_int;
      input [5:0] c;
      begin
         is_int = (c[5] == 1'b0) || (c == `MADS_OP_AUX);
      end
   endfunction

   function is_rf;
      input [5:0] c;
      begin
         is_rf = (c[5] == 1'b0);
      end
   endfunction

   function fill_bit;
      input [2:0] sel;
      input [3:0] fl;
      input own;
      input auxb;
      input sd;
      begin
         case (sel)
            `MADS_F_Z: fill_bit = fl[`MADS_FL_Z];
            `MADS_F_CY: fill_bit = fl[`MADS_FL_CY];
            `MADS_F_S: fill_bit = fl[`MADS_FL_S];
            `MADS_F_0: fill_bit = 1'b0;
            `MADS_F_1: fill_bit = 1'b1;
            `MADS_F_OWN: fill_bit = own;
            `MADS_F_AUX: fill_bit = auxb;
            default: fill_bit = sd;
         endcase
      end
   endfunction

   function [15:0] rd_op;
      input [5:0] c;
      begin
         if (is_rf(c))
            rd_op = rf[c[4:0]];
         else
            case (c)
               `MADS_OP_AUX: rd_op = aux_r;
               `MADS_OP_EXT0: rd_op = data_output_reg;
               `MADS_OP_EXT1: rd_op = port_output_reg;
               `MADS_OP_CONST: rd_op = const_r;
               `MADS_OP_SW: rd_op = sw_s2;
               default: rd_op = `MADS_RST_16;
            endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // instruction decode
   wire [5:0] dst = instr_r[`MADS_I_DST];
   wire [5:0] s1 = instr_r[`MADS_I_S1];
   wire [5:0] s2 = instr_r[`MADS_I_S2];
   wire two = instr_r[`MADS_I_TWO];
   wire [1:0] alu = instr_r[`MADS_I_ALU];
   wire [2:0] sec = instr_r[`MADS_I_SEC];
   wire [1:0] flow = instr_r[`MADS_I_FLOW];
   // two-operand form: dest is also first source
   wire [5:0] a_code = two ? dst : s1;
   wire [5:0] b_code = two ? s1 : s2;
   wire [15:0] a_val = rd_op(a_code);
   wire [15:0] b_val = rd_op(b_code);
   wire uses_const = (a_code == `MADS_OP_CONST) || (b_code == `MADS_OP_CONST);
   wire is_shift = (sec == `MADS_SEC_SHL) || (sec == `MADS_SEC_SHLD) ||
      (sec == `MADS_SEC_SHR);

   // distinct internal registers among dst, a, b
   wire [1:0] n_ab = (is_rf(a_code) && is_rf(b_code) && a_code != b_code) ? 2'h2 :
      ((is_rf(a_code) || is_rf(b_code)) ? 2'h1 : 2'h0);
   wire dst_new = is_rf(dst) && (dst != a_code) && (dst != b_code);
   wire ok2 = is_int(dst) || is_int(s1);
   wire ok3 = (is_int(s1) || is_int(s2)) &&
      !(is_rf(s1) && s1 == s2) && ({1'b0, n_ab} + {2'h0, dst_new} <= 3'h2);
   wire ok_flow = !uses_const || (flow == `MADS_FLOW_CONT);
   wire ok_copy = (sec != `MADS_SEC_COPY) || (is_int(dst) && is_rf(s2));
   wire ok_shift = !is_shift || (is_int(dst) && is_int(a_code) && is_int(b_code));
   wire ok_dst = (dst[5] == 1'b0) || (dst == `MADS_OP_AUX) || (dst == `MADS_OP_EXT0) ||
      (dst == `MADS_OP_EXT1);
   wire legal = (alu == `MADS_ALU_NOP) ||
      ((two ? ok2 : ok3) && ok_flow && ok_copy && ok_shift && ok_dst);

   ////////////////////////////////////////////////////////////////////////
   // alu
   wire cin = (alu == `MADS_ALU_ADC) ? flags_r[`MADS_FL_CY] : 1'b0;
   wire [16:0] sum = {1'b0, a_val} + {1'b0, b_val} + {16'h0000, cin};
   wire [15:0] res = (alu == `MADS_ALU_AND) ? (a_val & b_val) : sum[15:0];
   wire res_c = (alu == `MADS_ALU_AND) ? 1'b0 : sum[16];
   wire res_o = (alu == `MADS_ALU_AND) ? 1'b0 :
      ((a_val[15] == b_val[15]) && (res[15] != a_val[15]));
   wire [3:0] af = {res_o, res[15], res_c, (res == `MADS_RST_16)};
   wire sd = sd_s[1];
   // flags in the fill table are the ones before this instruction
   wire fl_bit = fill_bit(instr_r[`MADS_I_F1], flags_r, res[15], aux_r[15], sd);
   wire fr_bit = fill_bit(instr_r[`MADS_I_F1], flags_r, res[0], aux_r[0], sd);
   wire fq_bit = fill_bit(instr_r[`MADS_I_F2], flags_r, res[15], aux_r[15], sd);
   reg [15:0] wres;
   reg [3:0] fl_nxt;
   always @* begin
      wres = res;
      fl_nxt = af;
      case (sec)
         `MADS_SEC_SHL, `MADS_SEC_SHLD: wres = {res[14:0], fl_bit};
         `MADS_SEC_SHR: begin
            wres = {fr_bit, res[15:1]};
            // right shift z and s describe the shifted value, carry is the bit out, o stays the alu's
            fl_nxt = {af[3], fr_bit, res[0], (wres == `MADS_RST_16)};
         end
         default: wres = res;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt service: lowest pending enabled line wins
   wire [7:0] ready_irq = pend_r & ~mask_r;
   wire [7:0] pick = ready_irq & (~ready_irq + 8'h01);
   wire take = (pick != `MADS_RST_8) && !lock_r;
   wire exec = go_r && legal;
   wire allow = exec && (flow == `MADS_FLOW_ALLOW);
   wire [7:0] rise = irq_s2 & ~irq_d;
   wire [7:0] sw_clr = (exec && flow == `MADS_FLOW_CLR) ? instr_r[7:0] : `MADS_RST_8;

   // apb decode
   wire wr = psel && penable && pwrite && pready;
   wire rd_acc = psel && !penable;
   wire rf_hit = (paddr[11:8] == 4'h1) && (paddr[1:0] == 2'h0) && (paddr[7] == 1'b0);
   reg [31:0] rdat;
   reg hit;
   always @* begin
      rdat = 32'h0000_0000;
      hit = 1'b1;
      case (paddr)
         `MADS_A_INSTR: rdat = instr_r;
         `MADS_A_CONST: rdat = {16'h0000, const_r};
         `MADS_A_FLAGS: rdat = {27'h0, lock_r, flags_r};
         `MADS_A_AUX: rdat = {16'h0000, aux_r};
         `MADS_A_IRQ: rdat = {16'h0000, mask_r, pend_r};
         `MADS_A_STAT: rdat = {23'h0, go_r, err_cnt_r};
         `MADS_A_EXT0: rdat = {16'h0000, data_output_reg};
         `MADS_A_EXT1: rdat = {16'h0000, port_output_reg};
         default: begin
            if (rf_hit)
               rdat = {16'h0000, rf[paddr[6:2]]};
            else
               hit = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: only the second stage is read by logic
   // the switch word is quasi-static, so per-bit sync is enough
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sd_s <= `MADS_RST_2;
         sw_s1 <= `MADS_RST_16;
         sw_s2 <= `MADS_RST_16;
      end else begin
         sd_s <= {sd_s[0], serial_data_pin};
         sw_s1 <= switch_value_input;
         sw_s2 <= sw_s1;
      end
   end

   // interrupt lines: two stages, then a delayed copy for edge detection
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_s1 <= `MADS_RST_8;
         irq_s2 <= `MADS_RST_8;
         irq_d <= `MADS_RST_8;
      end else begin
         irq_s1 <= irq_in;
         irq_s2 <= irq_s1;
         irq_d <= irq_s2;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pending bits and service lock
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= `MADS_RST_8;
         irq_service_r <= `MADS_RST_1;
         lock_r <= `MADS_RST_1;
      end else begin
         // new edge wins over clears in the same cycle
         pend_r <= (pend_r & ~sw_clr & ~(take ? pick : `MADS_RST_8)) | rise;
         irq_service_r <= take;
         if (take)
            lock_r <= 1'b1;
         else if (allow)
            lock_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb answer: no wait state, answer in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `MADS_RST_32;
         pready <= `MADS_RST_1;
         pslverr <= `MADS_RST_1;
      end else begin
         pready <= rd_acc;
         pslverr <= rd_acc && !hit;
         if (rd_acc)
            prdata <= pwrite ? `MADS_RST_32 : rdat;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // instruction launch: go pulses the cycle after the write
   wire wr_hit = wr && hit;
   wire wr_instr = wr_hit && (paddr == `MADS_A_INSTR);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_r <= `MADS_RST_32;
         go_r <= `MADS_RST_1;
      end else begin
         go_r <= wr_instr;
         if (wr_instr)
            instr_r <= pwdata;
      end
   end

   // a refused instruction changes no state but this count and the output field
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_cnt_r <= `MADS_RST_8;
      end else begin
         if (go_r && !legal)
            err_cnt_r <= err_cnt_r + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags and the ext0/ext1 registers change only on an executed alu op
   wire alu_run = exec && (alu != `MADS_ALU_NOP);
   wire copy_run = alu_run && (sec == `MADS_SEC_COPY);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= `MADS_RST_4;
      end else begin
         if (alu_run)
            flags_r <= fl_nxt;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_control_field <= `MADS_RST_8;
         data_output_reg <= `MADS_RST_16;
         port_output_reg <= `MADS_RST_16;
      end else begin
         // output field latches even when the instruction is refused
         if (go_r)
            output_control_field <= instr_r[`MADS_I_OUT];
         if (alu_run && dst == `MADS_OP_EXT0)
            data_output_reg <= wres;
         if (alu_run && dst == `MADS_OP_EXT1)
            port_output_reg <= wres;
         // fill field zero picks ext0, anything else ext1
         if (copy_run && instr_r[`MADS_I_F1] == `MADS_F_Z)
            data_output_reg <= rf[s2[4:0]];
         if (copy_run && instr_r[`MADS_I_F1] != `MADS_F_Z)
            port_output_reg <= rf[s2[4:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register file: a software write lands after the alu result
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < `MADS_NREG; i = i + 1)
            rf[i] <= `MADS_RST_16;
      end else begin
         if (alu_run && is_rf(dst))
            rf[dst[4:0]] <= wres;
         if (wr_hit && rf_hit)
            rf[paddr[6:2]] <= pwdata[15:0];
      end
   end

   // aux, constant and mask
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_r <= `MADS_RST_16;
         const_r <= `MADS_RST_16;
         mask_r <= `MADS_RST_8;
      end else begin
         if (alu_run && dst == `MADS_OP_AUX)
            aux_r <= wres;
         // a double shift into aux itself keeps the primary result
         if (alu_run && sec == `MADS_SEC_SHLD && dst != `MADS_OP_AUX)
            aux_r <= {aux_r[14:0], fq_bit};
         if (wr_hit && paddr == `MADS_A_AUX)
            aux_r <= pwdata[15:0];
         if (wr_hit && paddr == `MADS_A_CONST)
            const_r <= pwdata[15:0];
         if (wr_hit && paddr == `MADS_A_IRQ)
            mask_r <= pwdata[15:8];
      end
   end

endmodule // mads_datapath

// [sim/mads_datapath_assertions.sv]
// Purpose: port-level checks of the alu/shifter datapath
// Assumes: one clock, apb answer in the first access cycle
// Notes: lock model clears only on an allow op written to the instruction port
`timescale 1ns/1ps
`include "mads_consts.vh"
module mads_datapath_assertions (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // pins
   input wire serial_data_pin,
   input wire [7:0] irq_in,
   input wire [15:0] switch_value_input,
   input wire [7:0] output_control_field,
   input wire [15:0] data_output_reg,
   input wire [15:0] port_output_reg,
   input wire irq_service_r
);
   wire ti = psel && penable && pready && pwrite && paddr == `MADS_A_INSTR;
   wire mapped = paddr[1:0] == 2'h0 && (paddr <= 12'h01C || paddr[11:7] == 5'h02);
   reg lock_r;
   ////////////////////////////////////////////////////////////////////////////////
   // an illegal allow op leaves this model clear: safe, never a false alarm
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         lock_r <= 1'b0;
      else if (irq_service_r)
         lock_r <= 1'b1;
      else if (ti && pwdata[31:30] == `MADS_FLOW_ALLOW)
         lock_r <= 1'b0;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   chk_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no answer in first access cycle");
   chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   chk_read_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   chk_outctl_follow: assert property (
      ti |-> ##2 output_control_field == $past(pwdata[7:0], 2))
      else $error("output field not latched");
   chk_outctl_cause: assert property (!$stable(output_control_field) |-> $past(ti, 2))
      else $error("output field moved without instruction");
   chk_ext0_cause: assert property (!$stable(data_output_reg) |-> $past(ti, 2))
      else $error("ext0 moved without instruction");
   chk_ext1_cause: assert property (!$stable(port_output_reg) |-> $past(ti, 2))
      else $error("ext1 moved without instruction");
   chk_serve_pulse: assert property (irq_service_r |=> !irq_service_r)
      else $error("service pulse too long");
   chk_serve_lock: assert property (irq_service_r |-> !lock_r)
      else $error("service while locked");
endmodule // mads_datapath_assertions
bind mads_datapath mads_datapath_assertions i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_data_pin(serial_data_pin),
   .irq_in(irq_in), .switch_value_input(switch_value_input),
   .output_control_field(output_control_field), .data_output_reg(data_output_reg),
   .port_output_reg(port_output_reg), .irq_service_r(irq_service_r));

// [sim/mads_datapath_test.sv]
// Purpose: self-checking bench of the alu/shifter datapath
// Assumes: apb master, fixed xorshift seed
// Notes: expected flags are tracked in fl from the random alu loop until the switch operand test
`timescale 1ns/1ps
`include "mads_consts.vh"
module mads_datapath_test;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, serial_data_pin = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, seed = 32'h7604, rd, r, il [0:5];
   reg [7:0] irq_in = 0, bad = 0;
   reg [15:0] switch_value_input = 0, a, b, res;
   reg [19:0] e;
   reg [3:0] fl = 0;
   reg [7:0] v;
   reg se;
   reg [1:0] op;
   integer errors = 0, comparisons = 0, i;
   wire [31:0] prdata;
   wire pready, pslverr, irq_service_r;
   wire [7:0] output_control_field;
   wire [15:0] data_output_reg, port_output_reg;
   mads_datapath i_mads_datapath (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serial_data_pin(serial_data_pin), .irq_in(irq_in),
      .switch_value_input(switch_value_input), .output_control_field(output_control_field),
      .data_output_reg(data_output_reg), .port_output_reg(port_output_reg),
      .irq_service_r(irq_service_r));
   ////////////////////////////////////////////////////////////////////////////////
   function [31:0] xs;
      input x;
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
   endfunction
   function [31:0] ins(input [1:0] f, input [2:0] f2, f1, sc, input t, input [1:0] al,
      input [5:0] s2, s1, d);
      ins = {f, f2, f1, sc, t, al, s2, s1, d};
   endfunction
   // result with flags {o,s,cy,z} above it
   function [19:0] ex(input [1:0] o, input [15:0] x, y, input c);
      reg [16:0] s;
      s = o == `MADS_ALU_AND ? {1'b0, x & y} : x + y + (o == `MADS_ALU_ADC ? c : 1'b0);
      ex = {o != `MADS_ALU_AND && x[15] == y[15] && s[15] != x[15], s[15], s[16],
         s[15:0] == 16'h0000, s[15:0]};
   endfunction
   task complete_run;
      if (errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string n, input [31:0] s, x);
      comparisons++;
      if (s !== x) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, x, s);
      end
   endtask
   task apb(input w, input [11:0] ad, input [31:0] d);
      integer n;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
         complete_run;
      end
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rdc(input string n, input [11:0] ad, input [31:0] x);
      apb(0, ad, 0);
      chk(n, rd, x);
   endtask
   task run(input [31:0] x);
      apb(1, `MADS_A_INSTR, x);
   endtask
   task waitsvc;
      integer n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (irq_service_r !== 1'b1 && n < 20);
      if (irq_service_r !== 1'b1) begin
         errors++;
         complete_run;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #10 pclk = ~pclk;
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      r = xs(0);
      switch_value_input <= r[15:0];
      rdc("flags", `MADS_A_FLAGS, 0);
      apb(1, `MADS_A_RF + 4, 32'hFFFF);
      apb(1, `MADS_A_CONST, 1);
      run(ins(0, 0, 0, 0, 1, `MADS_ALU_ADD, 0, `MADS_OP_CONST, 1));
      rdc("r1", `MADS_A_RF + 4, 0);
      rdc("flags", `MADS_A_FLAGS, 3);
      apb(1, `MADS_A_CONST, 0);
      run(ins(0, 0, 0, 0, 1, `MADS_ALU_ADC, 0, `MADS_OP_CONST, 1));
      rdc("r1", `MADS_A_RF + 4, 1);
      fl = 0;
      // three-form keeps to two internals: r2 and r4, the other source is the constant
      for (i = 0; i < 40; i++) begin
         r = xs(0);
         a = r[15:0];
         b = r[31:16];
         r = xs(0);
         op = r[1:0] == 2'h0 ? `MADS_ALU_ADD : r[1:0];
         apb(1, `MADS_A_RF + 8, a);
         apb(1, `MADS_A_CONST, b);
         run(r[2] ? ins(0, 0, 0, 0, 1, op, 0, `MADS_OP_CONST, 2)
            : ins(0, 0, 0, 0, 0, op, `MADS_OP_CONST, 2, 4));
         e = ex(op, a, b, fl[1]);
         fl = e[19:16];
         rdc("result", r[2] ? `MADS_A_RF + 8 : `MADS_A_RF + 16, e[15:0]);
         rdc("flags", `MADS_A_FLAGS, fl);
      end
      apb(1, `MADS_A_RF + 8, 32'hC000);
      apb(1, `MADS_A_AUX, 3);
      apb(1, `MADS_A_RF + 16, 32'hC003);
      for (i = 0; i < 16; i++) begin
         serial_data_pin <= i < 8;
         v = {i < 8, i >= 8, 2'b11, 1'b0, fl[2:0]};
         run(ins(0, 0, i % 8, i < 8 ? `MADS_SEC_SHL : `MADS_SEC_SHR, 0, `MADS_ALU_ADD,
            `MADS_OP_AUX, 2, 4));
         res = i < 8 ? {15'h4003, v[i % 8]} : {v[i % 8], 15'h6001};
         fl = i < 8 ? 4'h4 : {1'b0, v[i % 8], 2'b10};
         rdc("shift", `MADS_A_RF + 16, res);
         rdc("flags", `MADS_A_FLAGS, fl);
      end
      run(ins(0, `MADS_F_1, 0, `MADS_SEC_SHLD, 0, `MADS_ALU_ADD, `MADS_OP_AUX, 2, 4));
      fl = 4'h4;
      rdc("aux", `MADS_A_AUX, 7);
      run(ins(0, 0, 0, `MADS_SEC_COPY, 1, `MADS_ALU_ADD, 2, `MADS_OP_AUX, 4));
      rdc("ext0", `MADS_A_EXT0, 32'hC000);
      chk("ext0 pin", data_output_reg, 32'hC000);
      // r4 after the double shift, plus aux of seven
      e = ex(`MADS_ALU_ADD, 16'h8006, 16'h0007, 0);
      run(ins(0, 0, 1, `MADS_SEC_COPY, 1, `MADS_ALU_ADD, 4, `MADS_OP_AUX, 2));
      rdc("ext1", `MADS_A_EXT1, e[15:0]);
      chk("ext1 pin", port_output_reg, e[15:0]);
      il[0] = ins(0, 0, 0, 0, 1, `MADS_ALU_ADD, 0, `MADS_OP_CONST, `MADS_OP_EXT0);
      il[1] = ins(0, 0, 0, 0, 0, `MADS_ALU_ADD, 2, 2, 4);
      il[2] = ins(0, 0, 0, 0, 0, `MADS_ALU_ADD, 3, 2, 4);
      il[3] = ins(0, 0, 0, `MADS_SEC_SHL, 0, `MADS_ALU_ADD, `MADS_OP_CONST, 2, 4);
      il[4] = ins(1, 0, 0, 0, 1, `MADS_ALU_ADD, 0, `MADS_OP_CONST, 4);
      il[5] = ins(0, 0, 0, `MADS_SEC_COPY, 1, `MADS_ALU_ADD, 2, 3, `MADS_OP_EXT1);
      for (i = 0; i < 6; i++) begin
         run(il[i]);
         bad++;
         rdc("refusals", `MADS_A_STAT, bad);
      end
      rdc("flags", `MADS_A_FLAGS, fl);
      irq_in <= 8'h01;
      waitsvc;
      rdc("flags", `MADS_A_FLAGS, {27'h0, 1'b1, fl});
      rdc("irq", `MADS_A_IRQ, 0);
      irq_in <= 8'h03;
      for (i = 0; i < 10; i++) begin
         @(posedge pclk);
         chk("service", irq_service_r, 0);
      end
      rdc("irq", `MADS_A_IRQ, 2);
      run({`MADS_FLOW_ALLOW, 30'h0});
      waitsvc;
      rdc("flags", `MADS_A_FLAGS, {27'h0, 1'b1, fl});
      // a masked line stays pending until the clear op drops it
      apb(1, `MADS_A_IRQ, 32'h0400);
      irq_in <= 8'h07;
      repeat (4) @(posedge pclk);
      rdc("irq", `MADS_A_IRQ, 32'h0404);
      run({`MADS_FLOW_CLR, 22'h0, 8'h04});
      rdc("irq", `MADS_A_IRQ, 32'h0400);
      chk("outctl", output_control_field, 4);
      // switch operand into an external destination
      r = xs(0);
      a = r[15:0];
      apb(1, `MADS_A_RF + 8, a);
      run(ins(0, 0, 0, 0, 0, `MADS_ALU_ADD, `MADS_OP_SW, 2, `MADS_OP_EXT1));
      e = ex(`MADS_ALU_ADD, a, switch_value_input, 0);
      rdc("ext1", `MADS_A_EXT1, e[15:0]);
      chk("ext1 pin", port_output_reg, e[15:0]);
      rdc("flags", `MADS_A_FLAGS, {27'h0, 1'b1, e[19:16]});
      // unmapped address is refused
      apb(0, 12'h020, 0);
      chk("slverr", se, 1);
      chk("unmapped", rd, 0);
      complete_run;
   end
endmodule // mads_datapath_test
